// >>> irq_prio_defs.vh
// register offsets, field positions, reset values of the pin-interrupt
// and priority block; assumes an 8-bit register port with 3-bit address
`ifndef IRQ_PRIO_DEFS_VH
`define IRQ_PRIO_DEFS_VH

`define ADDR_PRIO_A      3'h0
`define ADDR_PRIO_B      3'h1
`define ADDR_FLAGS       3'h2
`define ADDR_ENABLES     3'h3
`define ADDR_SENSE       3'h4

`define RESET_BYTE       8'h00

`define PA_PINS_2_3      5
`define PA_PIN_4         4
`define PA_WATCHDOG      3
`define PA_TIMER_CH0     2
`define PA_TIMER_CH1     1
`define PA_TIMER_CH2     0
`define PA_PIN_0         7
`define PA_PIN_1         6
`define PB_TIMER_CH3     7
`define PB_TIMER_CH4     6
`define PB_SERIAL        3
`define PB_ADC           1

`define NUM_PINS         5
`define NUM_SRC          16

`endif

// >>> irq_prio_ctrl.v
// pin-interrupt flags, enables, sense selects and priority registers
// with a fixed-priority request resolver toward the cpu core.
// assumes synchronous pin inputs and a one-cycle acknowledge pulse.
//
// What this block does
// - priority-A bit 5 sets pins 2 and 3 jointly to high level
// - priority-A bit 4 sets pin 4 requests to high level
// - priority-A bit 3 sets the watchdog request level
// - priority-A bit 2 sets timer channel 0 request level
// - priority-A bit 1 sets timer channel 1 request level
// - priority-A bit 0 sets timer channel 2 request level
// - priority-B is 8-bit read/write, cleared by reset and standby
// - priority-B bit 7 sets timer channel 3 request level
// - priority-B bit 6 sets timer channel 4 request level
// - priority-B bit 3 sets the serial interface request level
// - priority-B bit 1 sets the converter request level
// - flag register bits 7 to 5 always read zero
// - software may only clear pin flags by writing zero
// - zero write clears a flag only after it was read as one
// - level mode sets the flag while the pin is low
// - level mode clears the flag on service when pin is high
// - edge mode sets the flag on a falling pin edge
// - edge mode clears the flag on service regardless of pin
// - flag and enable registers are 8-bit, reset to zero
// - enable bits 7 to 5 are inert storage; 4 to 0 gate pins
// - enable one passes a pin request, zero blocks it
// - sense select zero is level, one is falling edge; resets zero
// - high level wins; within a level lower vector wins
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defs.vh"

module irq_prio_ctrl (
  // clock and reset
  input  wire        MCLK,
  input  wire        RST,
  input  wire        HW_STANDBY,
  // register port
  input  wire [2:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  // external pins, active low
  input  wire [4:0]  PIN_IRQ_N,
  // peripheral request lines
  input  wire        WATCHDOG_REQ,
  input  wire [2:0]  TIMER_CH0_REQ,
  input  wire [2:0]  TIMER_CH1_REQ,
  input  wire [2:0]  TIMER_CH2_REQ,
  input  wire [2:0]  TIMER_CH3_REQ,
  input  wire [2:0]  TIMER_CH4_REQ,
  input  wire [3:0]  SERIAL_REQ,
  input  wire        ADC_REQ,
  // cpu side
  input  wire        ACK,
  input  wire [6:0]  ACK_VECTOR,
  output wire        REQ,
  output wire        REQ_LEVEL,
  output wire [6:0]  REQ_VECTOR
);

  reg  [7:0] prio_a_reg;
  reg  [7:0] prio_b_reg;
  reg  [4:0] flags_reg;
  reg  [4:0] flags_next;
  reg  [7:0] enables_reg;
  reg  [7:0] sense_reg;
  reg  [4:0] pin_prev_reg;
  reg  [4:0] read_one_reg;
  reg  [4:0] read_one_next;

  wire       clr = RST | HW_STANDBY;
  wire [4:0] pin_low = ~PIN_IRQ_N;
  wire [4:0] fall    = pin_prev_reg & ~PIN_IRQ_N;

  // pin vectors 12..16
  function [6:0] pin_vec;
    input [2:0] n;
    begin
      pin_vec = 7'h0c + {4'h0, n};
    end
  endfunction

  // register writes; standby clears like reset
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      prio_a_reg  <= `RESET_BYTE;
      prio_b_reg  <= `RESET_BYTE;
      enables_reg <= `RESET_BYTE;
      sense_reg   <= `RESET_BYTE;
    end else if (HW_STANDBY) begin
      prio_a_reg  <= `RESET_BYTE;
      prio_b_reg  <= `RESET_BYTE;
      enables_reg <= `RESET_BYTE;
      sense_reg   <= `RESET_BYTE;
    end else if (WR) begin
      case (ADDR)
        `ADDR_PRIO_A:  prio_a_reg  <= WDATA;
        `ADDR_PRIO_B:  prio_b_reg  <= WDATA;
        `ADDR_ENABLES: enables_reg <= WDATA;
        `ADDR_SENSE:   sense_reg   <= WDATA;
        default: ;
      endcase
    end
  end

  // flag state: hardware set beats write and service clears in the same cycle; the standby clear beats it
  integer i;
  always @* begin
    flags_next    = flags_reg;
    read_one_next = read_one_reg;
    for (i = 0; i < `NUM_PINS; i = i + 1) begin
      if (RD && ADDR == `ADDR_FLAGS)
        read_one_next[i] = flags_reg[i];
      if (WR && ADDR == `ADDR_FLAGS && !WDATA[i] && read_one_reg[i]) begin
        flags_next[i]    = 1'b0;
        read_one_next[i] = 1'b0;
      end
      if (ACK && ACK_VECTOR == pin_vec(i[2:0])) begin
        if (sense_reg[i])
          flags_next[i] = 1'b0;
        else if (!pin_low[i])
          flags_next[i] = 1'b0;
      end
      if (!sense_reg[i] && pin_low[i])
        flags_next[i] = 1'b1;
      if (sense_reg[i] && fall[i])
        flags_next[i] = 1'b1;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flags_reg    <= 5'h00;
      read_one_reg <= 5'h00;
      pin_prev_reg <= 5'h1f;
    end else if (HW_STANDBY) begin
      flags_reg    <= 5'h00;
      read_one_reg <= 5'h00;
      pin_prev_reg <= PIN_IRQ_N;
    end else begin
      flags_reg    <= flags_next;
      read_one_reg <= read_one_next;
      pin_prev_reg <= PIN_IRQ_N;
    end
  end

  // read data one cycle after the strobe
  always @(posedge MCLK or posedge RST) begin
    if (RST)
      RDATA <= 8'h00;
    else if (RD) begin
      case (ADDR)
        `ADDR_PRIO_A:  RDATA <= prio_a_reg;
        `ADDR_PRIO_B:  RDATA <= prio_b_reg;
        `ADDR_FLAGS:   RDATA <= {3'h0, flags_reg};
        `ADDR_ENABLES: RDATA <= enables_reg;
        `ADDR_SENSE:   RDATA <= sense_reg;
        default:       RDATA <= 8'h00;
      endcase
    end else
      RDATA <= 8'h00;
  end

  // source table in vector order; clr masks all while in standby
  reg [`NUM_SRC-1:0] src_req;
  reg [`NUM_SRC-1:0] src_lvl;
  reg [6:0]          src_vec [0:`NUM_SRC-1];
  wire [4:0] pin_pend = flags_reg & enables_reg[4:0];
  always @* begin
    src_req = {`NUM_SRC{1'b0}};
    src_req[0] = pin_pend[0];
    src_req[1] = pin_pend[1];
    src_req[2] = pin_pend[2];
    src_req[3] = pin_pend[3];
    src_req[4] = pin_pend[4];
    src_req[5] = WATCHDOG_REQ;
    src_req[6] = |TIMER_CH0_REQ;
    src_req[7] = |TIMER_CH1_REQ;
    src_req[8] = |TIMER_CH2_REQ;
    src_req[9] = |TIMER_CH3_REQ;
    src_req[10] = |TIMER_CH4_REQ;
    src_req[11] = |SERIAL_REQ;
    src_req[12] = ADC_REQ;
    src_req[15:13] = 3'h0;
    src_lvl = {`NUM_SRC{1'b0}};
    src_lvl[0]  = prio_a_reg[`PA_PIN_0];
    src_lvl[1]  = prio_a_reg[`PA_PIN_1];
    src_lvl[2]  = prio_a_reg[`PA_PINS_2_3];
    src_lvl[3]  = prio_a_reg[`PA_PINS_2_3];
    src_lvl[4]  = prio_a_reg[`PA_PIN_4];
    src_lvl[5]  = prio_a_reg[`PA_WATCHDOG];
    src_lvl[6]  = prio_a_reg[`PA_TIMER_CH0];
    src_lvl[7]  = prio_a_reg[`PA_TIMER_CH1];
    src_lvl[8]  = prio_a_reg[`PA_TIMER_CH2];
    src_lvl[9]  = prio_b_reg[`PB_TIMER_CH3];
    src_lvl[10] = prio_b_reg[`PB_TIMER_CH4];
    src_lvl[11] = prio_b_reg[`PB_SERIAL];
    src_lvl[12] = prio_b_reg[`PB_ADC];
    src_vec[0] = 7'd12; src_vec[1] = 7'd13; src_vec[2] = 7'd14;
    src_vec[3] = 7'd15; src_vec[4] = 7'd16; src_vec[5] = 7'd20;
    src_vec[6] = 7'd24; src_vec[7] = 7'd28; src_vec[8] = 7'd32;
    src_vec[9] = 7'd36; src_vec[10] = 7'd40; src_vec[11] = 7'd52;
    src_vec[12] = 7'd60; src_vec[13] = 7'd0; src_vec[14] = 7'd0;
    src_vec[15] = 7'd0;
    if (clr)
      src_req = {`NUM_SRC{1'b0}};
  end

  // lowest index in level 1 first, then level 0
  reg       win_found;
  reg       win_lvl;
  reg [6:0] win_vec;
  integer   k;
  always @* begin
    win_found = 1'b0;
    win_lvl   = 1'b0;
    win_vec   = 7'h00;
    for (k = `NUM_SRC - 1; k >= 0; k = k - 1)
      if (src_req[k] && src_lvl[k]) begin
        win_found = 1'b1;
        win_lvl   = 1'b1;
        win_vec   = src_vec[k];
      end
    if (!win_found)
      for (k = `NUM_SRC - 1; k >= 0; k = k - 1)
        if (src_req[k]) begin
          win_found = 1'b1;
          win_vec   = src_vec[k];
        end
  end

  assign REQ        = win_found;
  assign REQ_LEVEL  = win_lvl;
  assign REQ_VECTOR = win_vec;

endmodule // irq_prio_ctrl
`default_nettype wire

// >>> cpu_model.sv
// cpu core stand-in: acknowledges the current winner when told to
// assumes take is a one-cycle pulse on the block's clock
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic       clk, rst, take, req,
  input  wire logic [6:0] vec,
  output var  logic       ack,
  output var  logic [6:0] ack_vec
);
  // never two acks in a row, so one take cannot serve a stale vector
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      ack_vec <= 7'h00;
    end else begin
      ack <= take && req && !ack;
      ack_vec <= vec;
    end
  end
endmodule // cpu_model
`default_nettype wire

// >>> irq_prio_monitor.sv
// port checker of irq_prio_ctrl, bound to every instance
// shadows registers from the write strobe; one clock domain
`timescale 1ns/1ps
`default_nettype none
module irq_prio_monitor (
  input wire logic       MCLK, RST, HW_STANDBY, WR, RD,
  input wire logic       ACK, REQ, REQ_LEVEL, WATCHDOG_REQ,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA, RDATA,
  input wire logic [4:0] PIN_IRQ_N,
  input wire logic [6:0] ACK_VECTOR, REQ_VECTOR
);
  logic [7:0] sh [0:7];
  logic [7:0] exp_rd;
  wire  [6:0] ai = ACK_VECTOR - 7'h0c;
  wire  [6:0] ri = REQ_VECTOR - 7'h0c;
  wire        ap = ACK && ai < 7'h05;
  wire        low = |(~PIN_IRQ_N & ~sh[4][4:0] & sh[3][4:0]);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  always @(posedge MCLK or posedge RST) begin
    for (int i = 0; i < 8; i++)
      if (RST || HW_STANDBY)
        sh[i] <= 8'h00;
      else if (WR && ADDR == i[2:0])
        sh[i] <= WDATA;
    exp_rd <= (RST || ADDR > 3'h4) ? 8'h00 : sh[ADDR];
  end
  sequence pins_still;
    $stable(PIN_IRQ_N) ##1 $stable(PIN_IRQ_N);
  endsequence
  sequence pin_due;
    (low && !WR && !HW_STANDBY) [*2];
  endsequence
  chk_reg_readback:
    assert property (RD && ADDR != 3'h2 && !HW_STANDBY |=> RDATA == exp_rd)
      else $error("readback");
  chk_flag_top:
    assert property (RD && ADDR == 3'h2 |=> RDATA[7:5] == 3'h0)
      else $error("flag top");
  chk_standby_quiet:
    assert property (HW_STANDBY |-> !REQ) else $error("standby req");
  chk_enable_gate:
    assert property (REQ && ri < 7'h05 |-> sh[3][ri[2:0]])
      else $error("masked pin");
  chk_level_set:
    assert property (pin_due |=> REQ || HW_STANDBY) else $error("level set");
  chk_level_clear:
    assert property (pins_still ##0 (ap && !sh[4][ai[2:0]] &&
      PIN_IRQ_N[ai[2:0]]) |=> !(REQ && REQ_VECTOR == $past(ACK_VECTOR)))
      else $error("level clear");
  chk_edge_clear:
    assert property (pins_still ##0 (ap && sh[4][ai[2:0]])
      |=> !(REQ && REQ_VECTOR == $past(ACK_VECTOR))) else $error("edge clear");
  chk_wdog_level:
    assert property ((WATCHDOG_REQ && sh[0][3] && !WR && !HW_STANDBY) [*2]
      |-> REQ && REQ_LEVEL) else $error("wdog level");
endmodule // irq_prio_monitor
bind irq_prio_ctrl irq_prio_monitor u_mon (.MCLK(MCLK), .RST(RST),
  .HW_STANDBY(HW_STANDBY), .WR(WR), .RD(RD), .ACK(ACK), .REQ(REQ),
  .REQ_LEVEL(REQ_LEVEL), .WATCHDOG_REQ(WATCHDOG_REQ), .ADDR(ADDR),
  .WDATA(WDATA), .RDATA(RDATA), .PIN_IRQ_N(PIN_IRQ_N),
  .ACK_VECTOR(ACK_VECTOR), .REQ_VECTOR(REQ_VECTOR));
`default_nettype wire

// >>> testbench.sv
// bench of irq_prio_ctrl via its register port, pins and lines
// cpu_model answers requests; the port monitor is bound in
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        MCLK = 1'b0, RST = 1'b1, HW_STANDBY = 1'b0;
  logic        WR = 1'b0, RD = 1'b0, take = 1'b0;
  logic [2:0]  ADDR = 3'h0;
  logic [7:0]  WDATA = 8'h00;
  logic [4:0]  PIN_IRQ_N = 5'h1f;
  logic [20:0] per = 21'h0;
  wire         ACK, REQ, REQ_LEVEL;
  wire  [6:0]  ACK_VECTOR, REQ_VECTOR;
  wire  [7:0]  RDATA;
  int          fails = 0, checks_done = 0;
  int          pos [8] = '{0, 1, 4, 7, 10, 13, 16, 20};
  int          bitn [8] = '{3, 2, 1, 0, 7, 6, 3, 1};
  int          vec [8] = '{20, 24, 28, 32, 36, 40, 52, 60};
  initial forever #12.5 MCLK = ~MCLK;
  irq_prio_ctrl u_dut (.MCLK(MCLK), .RST(RST), .HW_STANDBY(HW_STANDBY),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PIN_IRQ_N(PIN_IRQ_N), .WATCHDOG_REQ(per[0]),
    .TIMER_CH0_REQ(per[3:1]), .TIMER_CH1_REQ(per[6:4]),
    .TIMER_CH2_REQ(per[9:7]), .TIMER_CH3_REQ(per[12:10]),
    .TIMER_CH4_REQ(per[15:13]), .SERIAL_REQ(per[19:16]),
    .ADC_REQ(per[20]), .ACK(ACK), .ACK_VECTOR(ACK_VECTOR), .REQ(REQ),
    .REQ_LEVEL(REQ_LEVEL), .REQ_VECTOR(REQ_VECTOR));
  cpu_model u_cpu (.clk(MCLK), .rst(RST), .take(take), .req(REQ),
    .vec(REQ_VECTOR), .ack(ACK), .ack_vec(ACK_VECTOR));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 chk({1'b0, RDATA}, {1'b0, e});
  endtask
  task automatic rq(input logic r, input logic l, input logic [6:0] v);
    #1 chk(r ? {REQ, REQ_LEVEL, REQ_VECTOR} : {8'h00, REQ}, {r, l, v});
  endtask
  task automatic pins(input logic [4:0] v);
    PIN_IRQ_N <= v;
    cyc(3);
  endtask
  task automatic ack_once();
    take <= 1'b1;
    cyc(1);
    take <= 1'b0;
    cyc(3);
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(2);
    RST <= 1'b0;
    for (int a = 0; a < 8; a++)
      rd(a[2:0], 8'h00);
    for (int a = 0; a < 8; a++) begin
      wr(a[2:0], 8'ha5);
      rd(a[2:0], (a == 2 || a > 4) ? 8'h00 : 8'ha5);
      wr(a[2:0], 8'h00);
    end
    // watchdog stays pending at level 0 as the rival of each later source; pass 0 tests the watchdog itself
    for (int k = 0; k < 8; k++) begin
      per <= 21'h1 | (21'h1 << pos[k]);
      wr(3'(k > 3), 8'h01 << bitn[k]);
      rq(1'b1, 1'b1, 7'(vec[k]));
      cyc(2);
      wr(3'(k > 3), k > 3 ? 8'h35 : 8'hc0);
      rq(1'b1, 1'b0, 7'h14);
    end
    per <= 21'h0;
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h1f);
    pins(5'h1b);
    rq(1'b1, 1'b0, 7'h0e);
    wr(3'h0, 8'h20);
    rq(1'b1, 1'b1, 7'h0e);
    pins(5'h1f);
    wr(3'h2, 8'h00);
    rd(3'h2, 8'h04);
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h04);
    wr(3'h2, 8'h00);
    rd(3'h2, 8'h00);
    pins(5'h1b);
    ack_once();
    rq(1'b1, 1'b1, 7'h0e);
    wr(3'h3, 8'he0);
    rq(1'b0, 1'b0, 7'h00);
    wr(3'h3, 8'h1f);
    pins(5'h1f);
    ack_once();
    rq(1'b0, 1'b0, 7'h00);
    wr(3'h4, 8'h10);
    wr(3'h0, 8'h10);
    pins(5'h0f);
    pins(5'h1f);
    rq(1'b1, 1'b1, 7'h10);
    pins(5'h0f);
    ack_once();
    rq(1'b0, 1'b0, 7'h00);
    pins(5'h1f);
    per <= 21'h1;
    HW_STANDBY <= 1'b1;
    cyc(1);
    rq(1'b0, 1'b0, 7'h00);
    HW_STANDBY <= 1'b0;
    per <= 21'h0;
    for (int a = 0; a < 5; a++)
      rd(a[2:0], 8'h00);
    test_done();
  end
  initial begin
    #50000;
    fails++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
